/* pioc_ext_dev.sv */
// Purpose: External devices and pull-ups on the I/O pins.
// Assumes: The bench commands each external driver.
// Notes:   A line nobody drives follows the pull-up, else the external keeper.
`timescale 1ns/100ps
module pioc_ext_dev (
  // Pad side of the controller
  input  wire logic [31:0] pin_out_i,
  input  wire logic [31:0] pin_oe_n_i,
  input  wire logic [31:0] pullup_en_i,
  // Bench commands
  input  wire logic [31:0] ext_val_i,
  input  wire logic [31:0] ext_en_i,
  // Resolved line level
  output logic      [31:0] pin_o
);
  // The pull-up only sets the level where no device drives the line.
  assign pin_o = ~pin_oe_n_i & pin_out_i |
                 pin_oe_n_i & ((ext_en_i | ~pullup_en_i) & ext_val_i | ~ext_en_i & pullup_en_i);
endmodule

/* pioc_pkg.sv */
// Purpose: Shared constants for the parallel I/O line controller.
// Assumes: APB byte addresses, 32-bit data, one bit per I/O line.
// Notes:   Offsets are byte addresses within the controller window.

package pioc_pkg;

  // --------------------------------------------------------------------
  // Widths
  // --------------------------------------------------------------------
  localparam int unsigned NUM_LINES  = 32;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;

  // --------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------
  localparam logic [7:0] OFS_LINE_OWN_EN     = 8'h00;
  localparam logic [7:0] OFS_LINE_OWN_DIS    = 8'h04;
  localparam logic [7:0] OFS_LINE_OWNER      = 8'h08;
  localparam logic [7:0] OFS_DRIVE_ON        = 8'h10;
  localparam logic [7:0] OFS_DRIVE_OFF       = 8'h14;
  localparam logic [7:0] OFS_DRIVE_STATE     = 8'h18;
  localparam logic [7:0] OFS_FILTER_ON       = 8'h20;
  localparam logic [7:0] OFS_FILTER_OFF      = 8'h24;
  localparam logic [7:0] OFS_FILTER_STATE    = 8'h28;
  localparam logic [7:0] OFS_LEVEL_SET       = 8'h30;
  localparam logic [7:0] OFS_LEVEL_CLEAR     = 8'h34;
  localparam logic [7:0] OFS_LEVEL_OUT       = 8'h38;
  localparam logic [7:0] OFS_PIN_LEVEL       = 8'h3C;
  localparam logic [7:0] OFS_IRQ_ON          = 8'h40;
  localparam logic [7:0] OFS_IRQ_OFF         = 8'h44;
  localparam logic [7:0] OFS_IRQ_MASK        = 8'h48;
  localparam logic [7:0] OFS_IRQ_FLAGS       = 8'h4C;
  localparam logic [7:0] OFS_OPEN_DRAIN_ON   = 8'h50;
  localparam logic [7:0] OFS_OPEN_DRAIN_OFF  = 8'h54;
  localparam logic [7:0] OFS_OPEN_DRAIN      = 8'h58;
  localparam logic [7:0] OFS_PULLUP_OFF      = 8'h60;
  localparam logic [7:0] OFS_PULLUP_ON       = 8'h64;
  localparam logic [7:0] OFS_PULLUP_STATE    = 8'h68;
  localparam logic [7:0] OFS_PERIPH_A_SEL    = 8'h70;
  localparam logic [7:0] OFS_PERIPH_B_SEL    = 8'h74;
  localparam logic [7:0] OFS_PERIPH_AB       = 8'h78;
  localparam logic [7:0] OFS_WMASK_ON        = 8'hA0;
  localparam logic [7:0] OFS_WMASK_OFF       = 8'hA4;
  localparam logic [7:0] OFS_WMASK_STATE     = 8'hA8;

  // --------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------
  localparam logic [31:0] RST_ZERO           = 32'h0000_0000;
  localparam logic [31:0] RST_OWNER_DEFAULT  = 32'hFFFF_FFFF;
  localparam logic [31:0] MUX_LINES_DEFAULT  = 32'hFFFF_FFFF;
  localparam logic [31:0] IMPL_LINES_DEFAULT = 32'hFFFF_FFFF;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int unsigned FILTER_LAT_CYC     = 1;

endpackage

/* pioc_top.sv */
// Purpose: Parallel I/O line controller with APB register access.
// Assumes: One 125 MHz clock; CLK_EN_I models the gated controller clock.
// Notes:   Register writes never depend on CLK_EN_I; level sampling after the synchroniser does.

`timescale 1ns/100ps

module pioc_top #(
  parameter logic [31:0] MUX_LINES  = pioc_pkg::MUX_LINES_DEFAULT,
  parameter logic [31:0] OWNER_RST  = pioc_pkg::RST_OWNER_DEFAULT,
  parameter logic [31:0] IMPL_LINES = pioc_pkg::IMPL_LINES_DEFAULT
) (
  // Clock, reset and controller clock gate
  input  wire logic        REF_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic        CLK_EN_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Pins
  input  wire logic [31:0] PIN_IN_I,
  output logic      [31:0] PIN_OUT_O,
  output logic      [31:0] PIN_OE_N_O,
  output logic      [31:0] PULLUP_EN_O,
  // Peripheral functions
  input  wire logic [31:0] PERA_OUT_I,
  input  wire logic [31:0] PERA_OE_I,
  input  wire logic [31:0] PERB_OUT_I,
  input  wire logic [31:0] PERB_OE_I,
  output logic      [31:0] PERIPH_IN_O,
  // Interrupt
  output logic             IRQ_O
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [31:0] pullup_state_ff;
  logic [31:0] line_owner_state_ff;
  logic [31:0] periph_ab_state_ff;
  logic [31:0] drive_state_ff;
  logic [31:0] level_out_state_ff;
  logic [31:0] direct_write_mask_state_ff;
  logic [31:0] open_drain_state_ff;
  logic [31:0] filter_state_ff;
  logic [31:0] change_irq_mask_ff;
  logic [31:0] change_irq_flags_ff;
  logic [31:0] pin_level_state_ff;
  logic [31:0] sync1_ff;
  logic [31:0] sync2_ff;
  logic [31:0] sync3_ff;
  logic        pready_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic [31:0] pin_out_ff;
  logic [31:0] pin_oe_n_ff;
  logic        irq_ff;
  logic        wr_done;
  logic        rd_done;
  logic [31:0] wdat;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic [31:0] filt_level;
  logic [31:0] nxt_level;
  logic [31:0] nxt_out;
  logic [31:0] nxt_oe;
  logic [31:0] pullup_en_ff;
  logic [31:0] flags_kept;

  function automatic logic wr_at(input logic [7:0] a, input logic [7:0] ofs);
    wr_at = (a == ofs);
  endfunction
  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // One wait state lets read data and error come straight from flip-flops.
  assign wr_done = PSEL_I & PENABLE_I & PWRITE_I & pready_ff;
  assign rd_done = PSEL_I & PENABLE_I & ~PWRITE_I & pready_ff;
  assign wdat    = PWDATA_I & IMPL_LINES;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (PADDR_I)
      pioc_pkg::OFS_LINE_OWN_EN, pioc_pkg::OFS_LINE_OWN_DIS, pioc_pkg::OFS_DRIVE_ON, pioc_pkg::OFS_DRIVE_OFF,
      pioc_pkg::OFS_FILTER_ON, pioc_pkg::OFS_FILTER_OFF, pioc_pkg::OFS_LEVEL_SET, pioc_pkg::OFS_LEVEL_CLEAR,
      pioc_pkg::OFS_IRQ_ON, pioc_pkg::OFS_IRQ_OFF, pioc_pkg::OFS_OPEN_DRAIN_ON, pioc_pkg::OFS_OPEN_DRAIN_OFF,
      pioc_pkg::OFS_PULLUP_OFF, pioc_pkg::OFS_PULLUP_ON, pioc_pkg::OFS_PERIPH_A_SEL, pioc_pkg::OFS_PERIPH_B_SEL,
      pioc_pkg::OFS_WMASK_ON, pioc_pkg::OFS_WMASK_OFF: rd_mux = 32'h0000_0000;
      pioc_pkg::OFS_LINE_OWNER:   rd_mux = line_owner_state_ff;
      pioc_pkg::OFS_DRIVE_STATE:  rd_mux = drive_state_ff;
      pioc_pkg::OFS_FILTER_STATE: rd_mux = filter_state_ff;
      pioc_pkg::OFS_LEVEL_OUT:    rd_mux = level_out_state_ff;
      pioc_pkg::OFS_PIN_LEVEL:    rd_mux = pin_level_state_ff;
      pioc_pkg::OFS_IRQ_MASK:     rd_mux = change_irq_mask_ff;
      pioc_pkg::OFS_IRQ_FLAGS:    rd_mux = change_irq_flags_ff;
      pioc_pkg::OFS_OPEN_DRAIN:   rd_mux = open_drain_state_ff;
      pioc_pkg::OFS_PULLUP_STATE: rd_mux = pullup_state_ff;
      pioc_pkg::OFS_PERIPH_AB:    rd_mux = periph_ab_state_ff;
      pioc_pkg::OFS_WMASK_STATE:  rd_mux = direct_write_mask_state_ff;
      default:                    rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= PSEL_I & PENABLE_I & ~pready_ff;
      pslverr_ff <= PSEL_I & PENABLE_I & ~pready_ff & ~rd_hit;
      if (PSEL_I && PENABLE_I && !pready_ff && !PWRITE_I) begin
        prdata_ff <= rd_mux & IMPL_LINES;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // None of these depend on CLK_EN_I, so software can configure a gated block.
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pullup_state_ff <= pioc_pkg::RST_ZERO;
      pullup_en_ff    <= IMPL_LINES;
    end else if (wr_done) begin
      if (wr_at(PADDR_I, pioc_pkg::OFS_PULLUP_ON)) begin
        pullup_state_ff <= pullup_state_ff & ~wdat;
        pullup_en_ff    <= pullup_en_ff | wdat;
      end else if (wr_at(PADDR_I, pioc_pkg::OFS_PULLUP_OFF)) begin
        pullup_state_ff <= pullup_state_ff | wdat;
        pullup_en_ff    <= pullup_en_ff & ~wdat;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      line_owner_state_ff <= OWNER_RST | ~MUX_LINES;
    end else if (wr_done) begin
      if (wr_at(PADDR_I, pioc_pkg::OFS_LINE_OWN_EN))
        line_owner_state_ff <= line_owner_state_ff | (wdat & MUX_LINES);
      else if (wr_at(PADDR_I, pioc_pkg::OFS_LINE_OWN_DIS))
        line_owner_state_ff <= line_owner_state_ff & ~(wdat & MUX_LINES);
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      periph_ab_state_ff <= pioc_pkg::RST_ZERO;
    end else if (wr_done) begin
      if (wr_at(PADDR_I, pioc_pkg::OFS_PERIPH_A_SEL)) periph_ab_state_ff <= periph_ab_state_ff & ~wdat;
      else if (wr_at(PADDR_I, pioc_pkg::OFS_PERIPH_B_SEL)) periph_ab_state_ff <= periph_ab_state_ff | wdat;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      drive_state_ff <= pioc_pkg::RST_ZERO;
    end else if (wr_done) begin
      if (wr_at(PADDR_I, pioc_pkg::OFS_DRIVE_ON)) drive_state_ff <= drive_state_ff | wdat;
      else if (wr_at(PADDR_I, pioc_pkg::OFS_DRIVE_OFF)) drive_state_ff <= drive_state_ff & ~wdat;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      level_out_state_ff <= pioc_pkg::RST_ZERO;
    end else if (wr_done) begin
      if (wr_at(PADDR_I, pioc_pkg::OFS_LEVEL_SET)) level_out_state_ff <= level_out_state_ff | wdat;
      else if (wr_at(PADDR_I, pioc_pkg::OFS_LEVEL_CLEAR)) level_out_state_ff <= level_out_state_ff & ~wdat;
      else if (wr_at(PADDR_I, pioc_pkg::OFS_LEVEL_OUT)) begin
        level_out_state_ff <= (level_out_state_ff & ~direct_write_mask_state_ff)
                            | (wdat & direct_write_mask_state_ff);
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      direct_write_mask_state_ff <= pioc_pkg::RST_ZERO;
    end else if (wr_done) begin
      if (wr_at(PADDR_I, pioc_pkg::OFS_WMASK_ON))
        direct_write_mask_state_ff <= direct_write_mask_state_ff | wdat;
      else if (wr_at(PADDR_I, pioc_pkg::OFS_WMASK_OFF))
        direct_write_mask_state_ff <= direct_write_mask_state_ff & ~wdat;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      open_drain_state_ff <= pioc_pkg::RST_ZERO;
    end else if (wr_done) begin
      if (wr_at(PADDR_I, pioc_pkg::OFS_OPEN_DRAIN_ON))
        open_drain_state_ff <= open_drain_state_ff | wdat;
      else if (wr_at(PADDR_I, pioc_pkg::OFS_OPEN_DRAIN_OFF))
        open_drain_state_ff <= open_drain_state_ff & ~wdat;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      filter_state_ff <= pioc_pkg::RST_ZERO;
    end else if (wr_done) begin
      if (wr_at(PADDR_I, pioc_pkg::OFS_FILTER_ON)) filter_state_ff <= filter_state_ff | wdat;
      else if (wr_at(PADDR_I, pioc_pkg::OFS_FILTER_OFF)) filter_state_ff <= filter_state_ff & ~wdat;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      change_irq_mask_ff <= pioc_pkg::RST_ZERO;
    end else if (wr_done) begin
      if (wr_at(PADDR_I, pioc_pkg::OFS_IRQ_ON)) change_irq_mask_ff <= change_irq_mask_ff | wdat;
      else if (wr_at(PADDR_I, pioc_pkg::OFS_IRQ_OFF)) change_irq_mask_ff <= change_irq_mask_ff & ~wdat;
    end
  end

  // ----------------------------------------------------------------------
  // Input sampling, glitch filter and change detection
  // ----------------------------------------------------------------------
  // The synchroniser runs on the free clock so peripherals always see the pin.
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sync1_ff <= pioc_pkg::RST_ZERO;
      sync2_ff <= pioc_pkg::RST_ZERO;
    end else begin
      sync1_ff <= PIN_IN_I;
      sync2_ff <= sync1_ff;
    end
  end

  // A filtered line accepts a new level only once two samples of all 32 lines agree.
  // This trades half-cycle resolution for a single clock domain.
  assign filt_level = (sync2_ff == sync3_ff) ? sync2_ff : pin_level_state_ff;
  assign nxt_level  = ((filter_state_ff & filt_level)
                    | (~filter_state_ff & sync2_ff)) & IMPL_LINES;
  assign flags_kept = (rd_done && PADDR_I == pioc_pkg::OFS_IRQ_FLAGS) ? pioc_pkg::RST_ZERO
                    : change_irq_flags_ff;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sync3_ff           <= pioc_pkg::RST_ZERO;
      pin_level_state_ff <= pioc_pkg::RST_ZERO;
    end else if (CLK_EN_I) begin
      sync3_ff           <= sync2_ff;
      pin_level_state_ff <= nxt_level;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      change_irq_flags_ff <= pioc_pkg::RST_ZERO;
    end else begin
      // A change in the reading cycle survives the clear.
      change_irq_flags_ff <= flags_kept | (CLK_EN_I ? nxt_level ^ pin_level_state_ff : 32'h0000_0000);
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(change_irq_flags_ff & change_irq_mask_ff);
    end
  end

  // ----------------------------------------------------------------------
  // Output path
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_out = 32'h0000_0000;
    nxt_oe  = 32'h0000_0000;
    for (int i = 0; i < pioc_pkg::NUM_LINES; i++) begin
      if (line_owner_state_ff[i]) begin
        nxt_out[i] = level_out_state_ff[i];
        nxt_oe[i]  = drive_state_ff[i];
      end else if (periph_ab_state_ff[i]) begin
        nxt_out[i] = PERB_OUT_I[i];
        nxt_oe[i]  = PERB_OE_I[i];
      end else begin
        nxt_out[i] = PERA_OUT_I[i];
        nxt_oe[i]  = PERA_OE_I[i];
      end
      // An open drain line releases the pin rather than driving it high.
      if (open_drain_state_ff[i]) begin
        nxt_oe[i]  = nxt_oe[i] & ~nxt_out[i];
        nxt_out[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pin_out_ff  <= pioc_pkg::RST_ZERO;
      pin_oe_n_ff <= 32'hFFFF_FFFF;
    end else begin
      pin_out_ff  <= nxt_out & IMPL_LINES;
      pin_oe_n_ff <= ~(nxt_oe & IMPL_LINES);
    end
  end

  assign PRDATA_O    = prdata_ff;
  assign PREADY_O    = pready_ff;
  assign PSLVERR_O   = pslverr_ff;
  assign PIN_OUT_O   = pin_out_ff;
  assign PIN_OE_N_O  = pin_oe_n_ff;
  assign PULLUP_EN_O = pullup_en_ff;
  assign PERIPH_IN_O = sync2_ff;
  assign IRQ_O       = irq_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);

  a_pullup_off_set:
    assert property (wr_done && PADDR_I == pioc_pkg::OFS_PULLUP_OFF
                     |=> (pullup_state_ff & $past(wdat)) == $past(wdat))
    else $error("Pull-up off write did not set state bits.");

  a_owner_fixed_lines:
    assert property ((line_owner_state_ff & ~MUX_LINES) == ~MUX_LINES)
    else $error("Line without peripheral lost controller ownership.");

  a_ab_select_b:
    assert property (wr_done && PADDR_I == pioc_pkg::OFS_PERIPH_B_SEL
                     |=> (periph_ab_state_ff & $past(wdat)) == $past(wdat))
    else $error("Select B write did not set A/B state.");

  a_owned_pin_drive:
    assert property (1'b1 |=> ((PIN_OE_N_O ^ ~$past(drive_state_ff))
                               & $past(line_owner_state_ff & ~open_drain_state_ff)) == 32'h0000_0000)
    else $error("Pin enable does not follow the drive decision.");

  a_masked_direct:
    assert property (wr_done && PADDR_I == pioc_pkg::OFS_LEVEL_OUT
                     |=> ((level_out_state_ff ^ $past(level_out_state_ff))
                          & ~$past(direct_write_mask_state_ff)) == 32'h0000_0000)
    else $error("Direct write changed a masked-off level bit.");

  a_open_drain_low:
    assert property (1'b1 |=> (~PIN_OE_N_O & PIN_OUT_O & $past(open_drain_state_ff)) == 32'h0000_0000)
    else $error("Open drain line driven high.");

  a_level_hold_gated:
    assert property (!CLK_EN_I |=> $stable(pin_level_state_ff))
    else $error("Pin level changed while the clock was gated.");

  a_change_sets_flag:
    assert property (CLK_EN_I && (nxt_level != pin_level_state_ff)
                     |=> (change_irq_flags_ff & $past(nxt_level ^ pin_level_state_ff))
                         == $past(nxt_level ^ pin_level_state_ff))
    else $error("Input change did not set its flag.");

  a_irq_or_mask:
    assert property (1'b1 |=> IRQ_O == |($past(change_irq_flags_ff & change_irq_mask_ff)))
    else $error("Interrupt output does not match flags and mask.");

  a_flags_read_clear:
    assert property (rd_done && PADDR_I == pioc_pkg::OFS_IRQ_FLAGS && !CLK_EN_I
                     |=> change_irq_flags_ff == 32'h0000_0000)
    else $error("Reading the flags did not clear them.");

endmodule

/* testbench.sv */
// Purpose: Self-checking bench for the parallel I/O line controller.
// Assumes: Default parameters, so every line is muxed and implemented.
// Notes:   Half-cycle glitch timing is not covered; the bench drives on edges.
`timescale 1ns/100ps
module testbench;
  // ----------------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------------
  logic        clk = 0, nrst = 0, clk_en = 1, psel = 0, pen = 0, pwr = 0, rdy, err, irq, se;
  logic [7:0]  padr = 8'h0;
  logic [7:0]  base [9] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'hA0};
  logic [31:0] pwd = 0, prd, pout, poe_n, pu_en, pa_o = 0, pa_e = 0, pb_o = 0, pb_e = 0, pin_in, per_in;
  logic [31:0] ext_v = 0, ext_e = 0, seed = 32'h15DA, q, d, o, oe, pin, old;
  logic [31:0] st [9];
  int          failures = 0, samples_checked = 0;

  always #4 clk = ~clk;

  pioc_top dut (.REF_CLK_I(clk), .NRST_I(nrst), .CLK_EN_I(clk_en), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err),
    .PIN_IN_I(pin_in), .PIN_OUT_O(pout), .PIN_OE_N_O(poe_n), .PULLUP_EN_O(pu_en), .PERA_OUT_I(pa_o),
    .PERA_OE_I(pa_e), .PERB_OUT_I(pb_o), .PERB_OE_I(pb_e), .PERIPH_IN_O(per_in), .IRQ_O(irq));
  pioc_ext_dev ext (.pin_out_i(pout), .pin_oe_n_i(poe_n), .pullup_en_i(pu_en), .ext_val_i(ext_v),
    .ext_en_i(ext_e), .pin_o(pin_in));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] pinf();
    return oe & o | ~oe & ((ext_e | st[6]) & ext_v | ~ext_e & ~st[6]);
  endfunction

  task automatic test_done();
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Holds the request until ready is sampled high; the bound cuts a hang short.
  task automatic apb(logic w, logic [7:0] a, logic [31:0] dat);
    int n;
    n = 0;
    psel <= 1'h1;
    pwr <= w;
    padr <= a;
    pwd <= dat;
    @(posedge clk) pen <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'h1 && n < 20);
    q = prd;
    se = err;
    psel <= 1'h0;
    pen <= 1'h0;
    if (rdy !== 1'h1) begin
      failures++;
      test_done();
    end
    @(posedge clk);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, e, q);
    chk("slverr_ok", 32'h0, {31'h0, se});
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    foreach (st[g]) st[g] = 32'h0;
    st[0] = 32'hFFFF_FFFF;
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    for (int g = 0; g < 9; g++) rd(base[g] + 8'h8, st[g], "reset");
    for (int g = 0; g < 9; g++) begin
      repeat (2) begin
        d = rnd();
        apb(1'h1, base[g] + (g == 7 ? 8'h4 : 8'h0), d);
        st[g] |= d;
        rd(base[g] + 8'h8, st[g], "set");
        d = rnd();
        apb(1'h1, base[g] + (g == 7 ? 8'h0 : 8'h4), d);
        st[g] &= ~d;
        rd(base[g] + 8'h8, st[g], "clear");
      end
      d = rnd();
      apb(1'h1, 8'h38, d);
      st[3] = st[3] & ~st[8] | d & st[8];
      rd(8'h38, st[3], "masked");
    end
    apb(1'h0, 8'h0C, 32'h0);
    chk("slverr", 32'h1, {31'h0, se});
    chk("unmapped", 32'h0, q);
    rd(8'h00, 32'h0, "wronly");
    for (int r = 0; r < 6; r++) begin
      for (int g = 0; g < 8; g++) begin
        d = rnd();
        apb(1'h1, base[g] + (g == 7 ? 8'h4 : 8'h0), d);
        apb(1'h1, base[g] + (g == 7 ? 8'h0 : 8'h4), ~d);
        st[g] = d;
      end
      pa_o <= rnd();
      pa_e <= rnd();
      pb_o <= rnd();
      pb_e <= rnd();
      ext_e <= rnd();
      ext_v <= rnd();
      repeat (8) @(posedge clk);
      o = st[0] & st[3] | ~st[0] & (st[7] & pb_o | ~st[7] & pa_o);
      oe = (st[0] & st[1] | ~st[0] & (st[7] & pb_e | ~st[7] & pa_e)) & ~(st[5] & o);
      pin = pinf();
      chk("oe_n", ~oe, poe_n);
      chk("out", o & oe, pout & oe);
      chk("pullup", ~st[6], pu_en);
      chk("periph_in", pin, per_in);
      rd(8'h3C, pin, "level");
      apb(1'h0, 8'h4C, 32'h0);
      old = pin;
      clk_en <= r[0];
      ext_v <= rnd();
      d = rnd();
      apb(1'h1, 8'h40, d);
      apb(1'h1, 8'h44, ~d);
      st[4] = d;
      rd(8'h48, st[4], "gated_wr");
      pin = pinf();
      rd(8'h3C, r[0] ? pin : old, "held");
      chk("irq", {31'h0, |((old ^ pin) & st[4]) & r[0]}, {31'h0, irq});
      rd(8'h4C, r[0] ? old ^ pin : 32'h0, "flags");
      rd(8'h4C, 32'h0, "cleared");
      clk_en <= 1'h1;
    end
    test_done();
  end
endmodule
